//--- shared/hwsv_pkg.sv
// constants and types shared by the host watchdog command block
package hwsv_pkg;
	localparam logic [7:0] CHAR_TILDE = 8'h7E;
	localparam logic [7:0] CHAR_CR = 8'h0D;
	localparam logic [7:0] CHAR_STAR = 8'h2A;
	localparam logic [7:0] CHAR_OK = 8'h21;
	localparam logic [7:0] CHAR_BAD = 8'h3F;
	localparam logic [7:0] CHAR_PLUS = 8'h2B;
	localparam logic [7:0] CHAR_MINUS = 8'h2D;
	localparam logic [7:0] CHAR_DOT = 8'h2E;
	localparam logic [3:0] OP_READ_STATE = 4'h0;
	localparam logic [3:0] OP_CLEAR_EXPIRY = 4'h1;
	localparam logic [3:0] OP_READ_CONFIG = 4'h2;
	localparam logic [3:0] OP_SET_WATCHDOG = 4'h3;
	localparam logic [3:0] OP_READ_PRESET = 4'h4;
	localparam logic [3:0] OP_STORE_FALLBACK = 4'h5;
	localparam int RX_MAX = 12;
	localparam int TX_MAX = 12;
	localparam int CHANNELS = 2;
	localparam logic [7:0] OUT_CHANNELS_MASK = 8'hFF;
	localparam int STATE_EXPIRED_BIT = 2;
	localparam int STATE_ENABLED_BIT = 7;
	localparam int CLOCK_HZ = 250000000;
	localparam int TENTH_MS = 100;
	localparam int TENTH_CYCLES = CLOCK_HZ / 1000 * TENTH_MS;
	localparam logic wd_enable_reset = 1'b0;
	localparam logic [7:0] wd_timeout_reset = 8'h00;
	localparam logic [7:0] mask_reset = 8'h00;
	localparam logic [23:0] fallback_reset = 24'h00_0000;
	typedef enum logic [3:0] {
		RX_IDLE = 4'b0001,
		RX_BODY = 4'b0010,
		RX_EXEC = 4'b0100,
		RX_SEND = 4'b1000
	} hwsv_rx_type;
endpackage

//--- hw/hwsv_cmd.sv
// host watchdog and output fallback command interpreter
// How it works
// RL1: tilde, address, '2', checksum optional, CR reads watchdog config.
// RL2: config reply is '!', address, enable digit, two timeout hex digits.
// RL3: returned timeout digits count tenths of a second.
// RL4: tilde, address, '3', enable digit, two timeout digits sets the watchdog.
// RL5: set timeout field counts tenths, 01 to FF.
// RL6: accepted set answers '!' and address only.
// RL7: well formed but impossible commands answer '?' and address.
// RL8: bad syntax, line error or foreign address gives silence.
// RL9: addresses are two hex chars; every reply echoes own address.
// RL10: a timeout clears the watchdog enable.
// RL11: host re-sends set command to re-arm after timeout.
// RL12: preset read answers '!', address, power-on mask, safe mask.
// RL13: power-on mask bit n is digital output n, 1 active.
// RL14: safe mask bit n is digital output n, 1 active.
// RL15: alarm-assigned outputs ignore power-on and safe masks.
// RL16: tilde, address, '4', channel 0-1 returns that channel's safe value.
// RL17: nonexistent analog channel answers '?'.
// RL18: store copies current analog output into safe value, answers '!'.
// RL19: tilde and two asterisks is host alive; never answered.
// RL20: state byte has expiry in bit 2, enable in bit 7; expiry sticky.
// RL21: tilde, address, '1' clears expiry flag and answers '!'.
// RL22: enabled watchdog counts tenths since host alive; timeout sets flag, safe outputs.
module hwsv_cmd (
	// clock and reset
	input wire logic clock,
	input wire logic rst_n,
	// received characters
	input wire logic [7:0] rxData,
	input wire logic rxValid,
	input wire logic rxError,
	// transmitted characters
	output logic [7:0] txData,
	output logic txValid,
	input wire logic txReady,
	// configuration
	input wire logic [7:0] nodeAddress,
	input wire logic [7:0] alarmAssign,
	input wire logic [7:0] doRequested,
	input wire logic [7:0] powerOnMaskIn,
	input wire logic [7:0] safeMaskIn,
	input wire logic maskLoad,
	input wire logic [15:0] aoCurrent0,
	input wire logic [15:0] aoCurrent1,
	// status and outputs
	output logic wdEnabled,
	output logic [7:0] timeoutSetting,
	output logic wdExpired,
	output logic safeActive,
	output logic [7:0] doOut,
	output logic [15:0] aoOut0,
	output logic [15:0] aoOut1
);
	hwsv_pkg::hwsv_rx_type state;
	logic [7:0] rxBuf [hwsv_pkg::RX_MAX];
	logic [3:0] rxLen;
	logic rxBad;
	logic [7:0] txBuf [hwsv_pkg::TX_MAX];
	logic [3:0] txLen;
	logic [3:0] txIdx;
	logic [7:0] powerOnMask;
	logic [7:0] safeMask;
	logic [15:0] fallback [hwsv_pkg::CHANNELS];
	logic [24:0] tenthCount;
	logic [7:0] tenths;
	logic hostAlive;
	logic [3:0] sumLen;
	logic sumOk;
	logic [7:0] addrByte;
	logic addrOk;
	logic [7:0] argByte;
	logic argOk;
	logic [3:0] op;
	logic opOk;

	// ascii hex digit to nibble, with validity in bit 4
	function automatic logic [4:0] hexValue(input logic [7:0] c);
		if (c >= 8'h30 && c <= 8'h39) begin
			hexValue = {1'b1, c[3:0]};
		end else if ((c >= 8'h41 && c <= 8'h46) || (c >= 8'h61 && c <= 8'h66)) begin
			hexValue = {1'b1, c[3:0] + 4'h9};
		end else begin
			hexValue = 5'h00;
		end
	endfunction

	function automatic logic [7:0] hexChar(input logic [3:0] n);
		hexChar = (n < 4'hA) ? {4'h3, n} : {4'h4, n - 4'h9};
	endfunction

	// checksum: low byte of sum of all chars before it
	function automatic logic [7:0] sumOf(input logic [7:0] b [hwsv_pkg::RX_MAX], input logic [3:0] n);
		logic [7:0] s;
		s = 8'h00;
		for (int i = 0; i < hwsv_pkg::RX_MAX; i++) begin
			if (4'(i) < n) begin
				s = s + b[i];
			end
		end
		sumOf = s;
	endfunction

	// frame decode: body is rxBuf[0..rxLen-1], no tilde, no CR
	always_comb begin
		logic [4:0] h0;
		logic [4:0] h1;
		logic [4:0] a0;
		logic [4:0] a1;
		logic [7:0] cs;
		// every local starts from a known value, no latch
		h0 = 5'h00;
		h1 = 5'h00;
		a0 = 5'h00;
		a1 = 5'h00;
		cs = 8'h00;
		h0 = hexValue(rxBuf[0]);
		h1 = hexValue(rxBuf[1]);
		addrByte = {h0[3:0], h1[3:0]};
		addrOk = h0[4] && h1[4] && addrByte == nodeAddress; // [RL9] [RL8]
		op = rxBuf[2][3:0];
		opOk = rxBuf[2][7:4] == 4'h3 && rxBuf[2][3:0] <= hwsv_pkg::OP_STORE_FALLBACK;
		a0 = hexValue(rxBuf[4]);
		a1 = hexValue(rxBuf[5]);
		argByte = {a0[3:0], a1[3:0]};
		argOk = a0[4] && a1[4];
		// optional trailing checksum: accept frame if last two chars match sum of the rest
		cs = sumOf(rxBuf, rxLen - 4'd2) + hwsv_pkg::CHAR_TILDE;
		sumLen = rxLen;
		sumOk = 1'b0;
		if (rxLen >= 4'd5) begin
			a0 = hexValue(rxBuf[rxLen - 4'd2]);
			a1 = hexValue(rxBuf[rxLen - 4'd1]);
			if (a0[4] && a1[4] && {a0[3:0], a1[3:0]} == cs) begin
				sumLen = rxLen - 4'd2;
				sumOk = 1'b1;
			end
		end
		hostAlive = rxLen == 4'd2 && rxBuf[0] == hwsv_pkg::CHAR_STAR && rxBuf[1] == hwsv_pkg::CHAR_STAR;
	end

	// receive, execute, send sequencing
	always_ff @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			state <= hwsv_pkg::RX_IDLE;
			rxLen <= 4'd0;
			rxBad <= 1'b0;
			txLen <= 4'd0;
			txIdx <= 4'd0;
			for (int i = 0; i < hwsv_pkg::RX_MAX; i++) begin
				rxBuf[i] <= 8'h00;
				txBuf[i] <= 8'h00;
			end
		end else begin
			case (state)
				hwsv_pkg::RX_IDLE: begin
					if (rxValid && !rxError && rxData == hwsv_pkg::CHAR_TILDE) begin
						rxLen <= 4'd0;
						rxBad <= 1'b0;
						state <= hwsv_pkg::RX_BODY;
					end
				end
				hwsv_pkg::RX_BODY: begin
					if (rxValid) begin
						if (rxError) begin
							rxBad <= 1'b1; // [RL8]
						end
						if (rxData == hwsv_pkg::CHAR_CR) begin
							state <= hwsv_pkg::RX_EXEC;
						end else if (rxLen == 4'(hwsv_pkg::RX_MAX)) begin
							rxBad <= 1'b1;
						end else begin
							rxBuf[rxLen] <= rxData;
							rxLen <= rxLen + 4'd1;
						end
					end
				end
				hwsv_pkg::RX_EXEC: begin
					txIdx <= 4'd0;
					txBuf[0] <= hwsv_pkg::CHAR_OK;
					// own address in upper case, whatever case the host typed
					txBuf[1] <= hexChar(nodeAddress[7:4]); // [RL9]
					txBuf[2] <= hexChar(nodeAddress[3:0]);
					txLen <= 4'd3; // [RL6] [RL21]
					state <= hwsv_pkg::RX_SEND;
					if (rxBad || hostAlive || !addrOk || !opOk) begin
						state <= hwsv_pkg::RX_IDLE; // [RL8] [RL19]
					end else begin
						case (op)
							hwsv_pkg::OP_READ_STATE: begin
								txBuf[3] <= hexChar({wdEnabled, 3'b000});
								txBuf[4] <= hexChar({1'b0, wdExpired, 2'b00}); // [RL20]
								txLen <= 4'd5;
								if (sumLen != 4'd3) state <= hwsv_pkg::RX_IDLE;
							end
							hwsv_pkg::OP_CLEAR_EXPIRY, hwsv_pkg::OP_STORE_FALLBACK: begin
								if (op == hwsv_pkg::OP_CLEAR_EXPIRY && sumLen != 4'd3) state <= hwsv_pkg::RX_IDLE;
								if (op == hwsv_pkg::OP_STORE_FALLBACK) begin
									if (sumLen != 4'd4) state <= hwsv_pkg::RX_IDLE;
									if (rxBuf[3] > 8'h31) txBuf[0] <= hwsv_pkg::CHAR_BAD; // [RL7]
								end
							end
							hwsv_pkg::OP_READ_CONFIG: begin
								txBuf[3] <= wdEnabled ? 8'h31 : 8'h30; // [RL2]
								txBuf[4] <= hexChar(timeoutSetting[7:4]); // [RL3]
								txBuf[5] <= hexChar(timeoutSetting[3:0]);
								txLen <= 4'd6;
								if (sumLen != 4'd3) state <= hwsv_pkg::RX_IDLE; // [RL1]
							end
							hwsv_pkg::OP_SET_WATCHDOG: begin
								if (sumLen != 4'd6 || !argOk || rxBuf[3] > 8'h31 || rxBuf[3] < 8'h30) begin
									state <= hwsv_pkg::RX_IDLE; // [RL4]
								end else if (argByte == 8'h00) begin
									txBuf[0] <= hwsv_pkg::CHAR_BAD; // [RL5] [RL7]
								end
							end
							hwsv_pkg::OP_READ_PRESET: begin
								if (sumLen == 4'd3) begin
									txBuf[3] <= hexChar(powerOnMask[7:4]); // [RL12]
									txBuf[4] <= hexChar(powerOnMask[3:0]);
									txBuf[5] <= hexChar(safeMask[7:4]);
									txBuf[6] <= hexChar(safeMask[3:0]);
									txLen <= 4'd7;
								end else if (sumLen == 4'd4) begin
									if (rxBuf[3] > 8'h31) begin
										txBuf[0] <= hwsv_pkg::CHAR_BAD; // [RL17]
									end else begin
										// fallback shown as a sign char from bit 15, then the four raw hex digits of the word
										txBuf[3] <= fallback[rxBuf[3][0]][15] ? hwsv_pkg::CHAR_MINUS : hwsv_pkg::CHAR_PLUS;
										txBuf[4] <= hexChar(fallback[rxBuf[3][0]][15:12]); // [RL16]
										txBuf[5] <= hexChar(fallback[rxBuf[3][0]][11:8]);
										txBuf[6] <= hexChar(fallback[rxBuf[3][0]][7:4]);
										txBuf[7] <= hexChar(fallback[rxBuf[3][0]][3:0]);
										txLen <= 4'd8;
									end
								end else begin
									state <= hwsv_pkg::RX_IDLE;
								end
							end
							default: state <= hwsv_pkg::RX_IDLE;
						endcase
					end
				end
				hwsv_pkg::RX_SEND: begin
					if (txReady) begin
						txIdx <= txIdx + 4'd1;
						if (txIdx == txLen) begin
							state <= hwsv_pkg::RX_IDLE;
						end
					end
				end
				default: state <= hwsv_pkg::RX_IDLE;
			endcase
		end
	end

	// reply stream; checksum omitted, CR closes it
	always_comb begin
		txValid = state == hwsv_pkg::RX_SEND;
		txData = (txIdx == txLen) ? hwsv_pkg::CHAR_CR : txBuf[txIdx];
	end

	wire execOk = state == hwsv_pkg::RX_EXEC && !rxBad && !hostAlive && addrOk && opOk;
	wire timeUp = wdEnabled && tenths >= timeoutSetting && timeoutSetting != 8'h00;

	// watchdog settings and sticky expiry
	always_ff @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			wdEnabled <= hwsv_pkg::wd_enable_reset;
			timeoutSetting <= hwsv_pkg::wd_timeout_reset;
			wdExpired <= 1'b0;
		end else begin
			if (execOk && op == hwsv_pkg::OP_SET_WATCHDOG && sumLen == 4'd6 && argOk && argByte != 8'h00
				&& (rxBuf[3] == 8'h30 || rxBuf[3] == 8'h31)) begin
				wdEnabled <= rxBuf[3][0]; // [RL4]
				timeoutSetting <= argByte; // [RL5]
			end
			if (execOk && op == hwsv_pkg::OP_CLEAR_EXPIRY && sumLen == 4'd3) begin
				wdExpired <= 1'b0; // [RL21]
			end
			// timeout wins over a same-cycle clear or set
			if (timeUp) begin
				wdExpired <= 1'b1; // [RL22] [RL20]
				wdEnabled <= 1'b0; // [RL10]
			end
		end
	end

	// tenth-second timer, restarted by host alive or by re-arming
	// a tenth is millions of cycles: short runs never see a timeout
	always_ff @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			tenthCount <= 25'd0;
			tenths <= 8'h00;
		end else if (!wdEnabled || (state == hwsv_pkg::RX_EXEC && hostAlive && !rxBad)) begin
			tenthCount <= 25'd0; // [RL19] [RL22]
			tenths <= 8'h00;
		end else if (tenthCount == 25'(hwsv_pkg::TENTH_CYCLES - 1)) begin
			tenthCount <= 25'd0;
			if (tenths != 8'hFF) tenths <= tenths + 8'h01;
		end else begin
			tenthCount <= tenthCount + 25'd1;
		end
	end

	// masks and analog fallback values
	always_ff @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			powerOnMask <= hwsv_pkg::mask_reset;
			safeMask <= hwsv_pkg::mask_reset;
			fallback[0] <= hwsv_pkg::fallback_reset[15:0];
			fallback[1] <= hwsv_pkg::fallback_reset[15:0];
		end else begin
			if (maskLoad) begin
				powerOnMask <= powerOnMaskIn; // [RL13]
				safeMask <= safeMaskIn; // [RL14]
			end
			if (execOk && op == hwsv_pkg::OP_STORE_FALLBACK && sumLen == 4'd4 && rxBuf[3] <= 8'h31) begin
				fallback[rxBuf[3][0]] <= rxBuf[3][0] ? aoCurrent1 : aoCurrent0; // [RL18]
			end
		end
	end

	// output selection; alarm channels pass through untouched
	always_ff @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			doOut <= 8'h00;
			aoOut0 <= 16'h0000;
			aoOut1 <= 16'h0000;
		end else if (wdExpired) begin
			doOut <= (safeMask & ~alarmAssign) | (doRequested & alarmAssign); // [RL22] [RL15]
			aoOut0 <= fallback[0];
			aoOut1 <= fallback[1];
		end else begin
			doOut <= doRequested;
			aoOut0 <= aoCurrent0;
			aoOut1 <= aoCurrent1;
		end
	end

	assign safeActive = wdExpired;
endmodule // hwsv_cmd

//--- tb/hwsv_host.sv
// host controller model: sends frames, collects replies
module hwsv_host (
	// clock
	input wire logic clock,
	// frames towards the block
	output logic [7:0] rxData,
	output logic rxValid,
	output logic rxError,
	// replies from the block
	input wire logic [7:0] txData,
	input wire logic txValid,
	output logic txReady
);
	timeunit 1ns;
	timeprecision 1ps;
	string reply;
	bit done;
	bit slow;
	initial begin
		rxData = 8'h00;
		rxValid = 1'b0;
		rxError = 1'b0;
		txReady = 1'b1;
	end
	function automatic logic [7:0] hx(input logic [3:0] n);
		return (n < 4'hA) ? 8'h30 + n : 8'h37 + n;
	endfunction
	// a busy host stalls every other cycle
	always @(negedge clock) txReady <= slow ? ~txReady : 1'b1;
	always @(posedge clock) begin
		if (txValid && txReady) begin
			if (txData == hwsv_pkg::CHAR_CR) done = 1'b1;
			else reply = {reply, string'(txData)};
		end
	end
	task automatic put(input logic [7:0] c, input bit err);
		@(negedge clock);
		rxData <= c;
		rxValid <= 1'b1;
		rxError <= err;
		@(negedge clock);
		rxValid <= 1'b0;
		rxError <= 1'b0;
		rxData <= ~c; // idle line shows no stale char
	endtask
	// one frame, then wait for reply end or a silent spell
	task automatic frame(input string body, input bit ck, input bit err);
		logic [7:0] sum;
		sum = hwsv_pkg::CHAR_TILDE;
		reply = "";
		done = 1'b0;
		put(hwsv_pkg::CHAR_TILDE, 1'b0);
		foreach (body[i]) begin
			put(body[i], err && i == 1);
			sum += body[i];
		end
		if (ck) begin
			put(hx(sum[7:4]), 1'b0);
			put(hx(sum[3:0]), 1'b0);
		end
		put(hwsv_pkg::CHAR_CR, 1'b0);
		for (int n = 0; n < 60 && !done; n++) @(posedge clock);
	endtask
endmodule // hwsv_host

//--- tb/hwsv_cmd_assertions.sv
// port assertions for the host watchdog command block
module hwsv_cmd_assertions (
	// clock and reset
	input wire logic clock,
	input wire logic rst_n,
	// characters
	input wire logic [7:0] rxData,
	input wire logic rxValid,
	input wire logic [7:0] txData,
	input wire logic txValid,
	input wire logic txReady,
	// configuration and outputs
	input wire logic [7:0] nodeAddress,
	input wire logic [7:0] alarmAssign,
	input wire logic [7:0] doRequested,
	input wire logic [15:0] aoCurrent0,
	input wire logic wdEnabled,
	input wire logic [7:0] timeoutSetting,
	input wire logic wdExpired,
	input wire logic safeActive,
	input wire logic [7:0] doOut,
	input wire logic [15:0] aoOut0
);
	logic [3:0] sinceCr;
	logic [2:0] txIdx;
	function automatic logic [7:0] hx(input logic [3:0] n);
		return (n < 4'hA) ? 8'h30 + n : 8'h37 + n;
	endfunction
	// saturates so a long idle spell never looks like a fresh frame end
	always_ff @(posedge clock or negedge rst_n) begin
		if (!rst_n) sinceCr <= 4'hF;
		else if (rxValid && rxData == hwsv_pkg::CHAR_CR) sinceCr <= 4'h0;
		else if (sinceCr != 4'hF) sinceCr <= sinceCr + 4'h1;
	end
	always_ff @(posedge clock or negedge rst_n) begin
		if (!rst_n) txIdx <= 3'h0;
		else if (!txValid) txIdx <= 3'h0;
		else if (txReady) txIdx <= txIdx + 3'h1;
	end
	default clocking @(posedge clock); endclocking
	default disable iff (!rst_n);
	property p_safe; safeActive == wdExpired; endproperty
	a_safe: assert property (p_safe) else $error("safe flag differs from expiry");
	property p_expire; $rose(wdExpired) |-> !wdEnabled; endproperty
	a_expire: assert property (p_expire) else $error("enable kept on expiry");
	property p_hold; txValid && !txReady |=> txValid && $stable(txData); endproperty
	a_hold: assert property (p_hold) else $error("reply char dropped");
	property p_lead; $rose(txValid) |-> txData == hwsv_pkg::CHAR_OK || txData == hwsv_pkg::CHAR_BAD; endproperty
	a_lead: assert property (p_lead) else $error("bad reply lead char");
	property p_cause; $rose(txValid) |-> sinceCr == 4'h1; endproperty
	a_cause: assert property (p_cause) else $error("reply not two cycles after frame end");
	property p_addr; txValid && (txIdx == 3'h1 || txIdx == 3'h2)
		|-> txData == hx(txIdx[0] ? nodeAddress[7:4] : nodeAddress[3:0]); endproperty
	a_addr: assert property (p_addr) else $error("address not echoed");
	property p_end; txValid && txReady && txData == hwsv_pkg::CHAR_CR |=> !txValid; endproperty
	a_end: assert property (p_end) else $error("reply runs past its end");
	property p_alarm; 1 |=> (doOut & $past(alarmAssign)) == ($past(doRequested) & $past(alarmAssign)); endproperty
	a_alarm: assert property (p_alarm) else $error("alarm channel altered");
	property p_normal; !wdExpired ##1 !wdExpired |-> aoOut0 == $past(aoCurrent0); endproperty
	a_normal: assert property (p_normal) else $error("analog output not normal");
	property p_sticky; $fell(wdExpired) |-> sinceCr <= 4'h3; endproperty
	a_sticky: assert property (p_sticky) else $error("expiry cleared without command");
	property p_cfg; $changed(timeoutSetting) || $rose(wdEnabled) |-> sinceCr <= 4'h3; endproperty
	a_cfg: assert property (p_cfg) else $error("setting changed without command");
	cover property ($rose(txValid) && txData == hwsv_pkg::CHAR_BAD);
	cover property ($rose(wdEnabled));
	cover property (txValid && txIdx == 3'h7);
endmodule // hwsv_cmd_assertions
bind hwsv_cmd hwsv_cmd_assertions chk (.clock(clock), .rst_n(rst_n), .rxData(rxData), .rxValid(rxValid),
	.txData(txData), .txValid(txValid), .txReady(txReady), .nodeAddress(nodeAddress), .alarmAssign(alarmAssign),
	.doRequested(doRequested), .aoCurrent0(aoCurrent0), .wdEnabled(wdEnabled), .timeoutSetting(timeoutSetting),
	.wdExpired(wdExpired), .safeActive(safeActive), .doOut(doOut), .aoOut0(aoOut0));

//--- tb/tb_hwsv_cmd.sv
// self-checking bench for the host watchdog command block
`define CHK(got, exp) begin samples_checked++; if (((got) == (exp)) !== 1'b1) begin bad_count++; \
	$display("mismatch at %0t: value differs from expected", $time); end end
module tb_hwsv_cmd;
	timeunit 1ns;
	timeprecision 1ps;
	logic clock, rst_n, rxValid, rxError, txValid, txReady, maskLoad;
	logic wdEnabled, wdExpired, safeActive;
	logic [7:0] rxData, txData, nodeAddress, alarmAssign, doRequested;
	logic [7:0] powerOnMaskIn, safeMaskIn, timeoutSetting, doOut;
	logic [15:0] aoCurrent0, aoCurrent1, aoOut0, aoOut1;
	int bad_count = 0;
	int samples_checked = 0;
	hwsv_cmd uut (.clock(clock), .rst_n(rst_n), .rxData(rxData), .rxValid(rxValid), .rxError(rxError),
		.txData(txData), .txValid(txValid), .txReady(txReady), .nodeAddress(nodeAddress),
		.alarmAssign(alarmAssign), .doRequested(doRequested), .powerOnMaskIn(powerOnMaskIn),
		.safeMaskIn(safeMaskIn), .maskLoad(maskLoad), .aoCurrent0(aoCurrent0), .aoCurrent1(aoCurrent1),
		.wdEnabled(wdEnabled), .timeoutSetting(timeoutSetting), .wdExpired(wdExpired),
		.safeActive(safeActive), .doOut(doOut), .aoOut0(aoOut0), .aoOut1(aoOut1));
	hwsv_host host (.clock(clock), .rxData(rxData), .rxValid(rxValid), .rxError(rxError), .txData(txData),
		.txValid(txValid), .txReady(txReady));
	task automatic finish_test;
		$display("mismatches %0d, checks %0d", bad_count, samples_checked);
		if (bad_count == 0 && samples_checked > 0) $display("Simulation passed");
		else $display("Simulation failed");
		$finish;
	endtask
	task automatic cmd(input string body, input string exp, input bit ck = 0, input bit err = 0);
		host.frame(body, ck, err);
		`CHK(host.reply, exp)
	endtask
	initial begin
		clock = 1'b0;
		forever #2 clock = ~clock;
	end
	// far longer than the whole sequence needs
	initial begin
		#100000;
		bad_count++;
		finish_test();
	end
	initial begin
		rst_n = 1'b0;
		nodeAddress = 8'h5A;
		alarmAssign = 8'h0F;
		doRequested = 8'hA5;
		powerOnMaskIn = 8'h00;
		safeMaskIn = 8'h00;
		maskLoad = 1'b0;
		aoCurrent0 = 16'h1234;
		aoCurrent1 = 16'h8ABC;
		repeat (6) @(posedge clock);
		`CHK({wdEnabled, wdExpired, safeActive, txValid, timeoutSetting}, 12'h000)
		@(negedge clock);
		rst_n = 1'b1;
		cmd("5A2", "!5A000");
		cmd("5A3164", "!5A");
		`CHK({wdEnabled, timeoutSetting}, 9'h164)
		cmd("5A2", "!5A164", 1);
		cmd("5A0", "!5A80");
		host.slow = 1'b1;
		cmd("5A30FF", "!5A");
		`CHK({wdEnabled, timeoutSetting}, 9'h0FF)
		cmd("5A2", "!5A0FF");
		host.slow = 1'b0;
		cmd("5A3100", "?5A");
		cmd("5A2", "!5A0FF");
		cmd("5B2", "");
		cmd("5A2", "", 0, 1);
		cmd("5A9", "");
		cmd("**", "");
		@(negedge clock);
		powerOnMaskIn = 8'h01;
		safeMaskIn = 8'h02;
		maskLoad = 1'b1;
		@(negedge clock);
		maskLoad = 1'b0;
		cmd("5A4", "!5A0102");
		cmd("5A50", "!5A");
		cmd("5A51", "!5A");
		@(negedge clock);
		aoCurrent0 = 16'h0000;
		cmd("5A40", "!5A+1234");
		cmd("5A41", "!5A-8ABC");
		cmd("5A42", "?5A");
		cmd("5A52", "?5A");
		cmd("5A1", "!5A");
		cmd("5A0", "!5A00");
		`CHK(doOut, 8'hA5)
		`CHK({aoOut0, aoOut1}, 32'h0000_8ABC)
		finish_test();
	end
endmodule // tb_hwsv_cmd
